// [hdl/eau_pkg.sv]
package eau_pkg;

	localparam int EAU_REG_COUNT = 8;
	localparam int EAU_SEL_W     = 3;
	localparam int EAU_ADDR_W    = 32;

	// operand addressing modes
	typedef enum logic [4:0] {
		MODE_DREG      = 5'h00,
		MODE_AREG      = 5'h01,
		MODE_AIND      = 5'h02,
		MODE_APOST     = 5'h03,
		MODE_APRE      = 5'h04,
		MODE_ADISP     = 5'h05,
		MODE_AIDX8     = 5'h06,
		MODE_AIDXBD    = 5'h07,
		MODE_AMIPOST   = 5'h08,
		MODE_AMIPRE    = 5'h09,
		MODE_PCDISP    = 5'h0A,
		MODE_PCIDX8    = 5'h0B,
		MODE_PCIDXBD   = 5'h0C,
		MODE_PCMIPOST  = 5'h0D,
		MODE_PCMIPRE   = 5'h0E,
		MODE_ABSW      = 5'h0F,
		MODE_ABSL      = 5'h10,
		MODE_IMM       = 5'h11
	} eau_mode_t;

	typedef enum logic [1:0] {
		SIZE_BYTE = 2'h0,
		SIZE_WORD = 2'h1,
		SIZE_LONG = 2'h2
	} eau_size_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b01,
		ST_FETCH = 2'b10
	} eau_state_t;

	localparam logic [31:0] EAU_ZERO     = 32'h0000_0000;
	localparam logic [31:0] EAU_STEP_B   = 32'h0000_0001;
	localparam logic [31:0] EAU_STEP_W   = 32'h0000_0002;
	localparam logic [31:0] EAU_STEP_L   = 32'h0000_0004;
	localparam logic        EAU_READY_RST = 1'b1;

	function automatic logic [31:0] eau_sext8(input logic [7:0] v);
		return {{24{v[7]}}, v};
	endfunction

	function automatic logic [31:0] eau_sext16(input logic [15:0] v);
		return {{16{v[15]}}, v};
	endfunction

	function automatic logic [31:0] eau_disp(input logic [31:0] v, input logic is_long);
		return is_long ? v : eau_sext16(v[15:0]);
	endfunction

	function automatic logic [31:0] eau_step(input eau_size_t s);
		case (s)
			SIZE_BYTE: return EAU_STEP_B;
			SIZE_WORD: return EAU_STEP_W;
			default:   return EAU_STEP_L;
		endcase
	endfunction

	function automatic logic [31:0] eau_pick(input logic [255:0] bank, input logic [2:0] sel);
		return bank[{sel, 5'h00} +: 32];
	endfunction

endpackage

// [hdl/eau_index_scale.sv]
`timescale 1ns/10ps
module eau_index_scale
	import eau_pkg::*;
(
	input  wire logic [255:0] data_regs,
	input  wire logic [255:0] addr_regs,
	input  wire logic [2:0]   index_reg_sel,
	input  wire logic         index_is_addr,
	input  wire logic         index_long,
	input  wire logic [1:0]   index_scale,
	output logic      [31:0]  scaled_index
);

	logic [31:0] raw;
	logic [31:0] sized;

	always_comb begin
		raw          = index_is_addr ? eau_pick(addr_regs, index_reg_sel) : eau_pick(data_regs, index_reg_sel); // RL4
		sized        = index_long ? raw : eau_sext16(raw[15:0]); // RL4
		scaled_index = sized << index_scale; // RL5
	end

endmodule

// [hdl/eau_unit.sv]
`timescale 1ns/10ps
// Behaviour
// (RL1) Any of the eight data registers can be picked by data_reg_sel as operand, or by index_reg_sel as index.
// (RL2) Any of the eight address registers can be picked by addr_reg_sel as operand or base.
// (RL3) Short displacements of 8 or 16 bits are sign-extended to 32 bits and added in.
// (RL4) The index comes from a data or address register, as sign-extended word or full long.
// (RL5) The index is multiplied by 1, 2, 4 or 8 before being added; size and scale are optional.
// (RL6) A base displacement is 16 or 32 bits, extended to 32 bits before addition.
// (RL7) The optional outer displacement of 16 or 32 bits is added only after memory indirection.
// (RL8) Memory indirect modes fetch a long word at the inner address and use it as intermediate address.
// (RL9) Pre-indexed adds the index before the fetch, post-indexed adds it after with the outer displacement.
// (RL10) Program counter with displacement gives pc plus a sign-extended 16-bit displacement.
// (RL11) Short indexed modes add base register or pc, a sign-extended 8-bit displacement and the scaled index.
// (RL12) Postincrement uses the register then advances it; predecrement reduces it first.
// (RL13) Immediate mode takes an 8, 16 or 32-bit operand from the instruction stream.
// (RL14) Eighteen addressing modes are served on byte, word and long operands.
// (RL15) Absolute short sign-extends a 16-bit address; absolute long uses the full 32 bits.
// (RL16) The postincrement and predecrement step equals the operand size in bytes.
module eau_unit
	import eau_pkg::*;
#(
	parameter int REG_COUNT = EAU_REG_COUNT
)(
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          req_valid,
	input  wire eau_mode_t     req_mode,
	input  wire eau_size_t     req_size,
	input  wire logic [2:0]    data_reg_sel,
	input  wire logic [2:0]    addr_reg_sel,
	input  wire logic [2:0]    index_reg_sel,
	input  wire logic          index_is_addr,
	input  wire logic          index_long,
	input  wire logic [1:0]    index_scale,
	input  wire logic [7:0]    short_disp_byte,
	input  wire logic [15:0]   short_disp_word,
	input  wire logic [31:0]   base_disp,
	input  wire logic          base_disp_long,
	input  wire logic [31:0]   outer_disp,
	input  wire logic          outer_disp_used,
	input  wire logic          outer_disp_long,
	input  wire logic [31:0]   ext_data,
	input  wire logic [31:0]   pc,
	input  wire logic [255:0]  data_regs,
	input  wire logic [255:0]  addr_regs,
	input  wire logic          mem_rd_ack,
	input  wire logic [31:0]   mem_rd_data,
	output logic               req_ready,
	output logic               ea_valid,
	output logic [31:0]        ea_addr,
	output logic               operand_is_reg,
	output logic               operand_is_imm,
	output logic [31:0]        operand_value,
	output logic               an_wr_en,
	output logic [2:0]         an_wr_sel,
	output logic [31:0]        an_wr_val,
	output logic               mem_rd_req,
	output logic [31:0]        mem_rd_addr
);

	generate
		if (REG_COUNT != EAU_REG_COUNT) begin : g_bad_count
			$error("eau_unit: register count must be eight");
		end
	endgenerate

	eau_state_t  state_reg,  state_next;
	logic        ready_reg,  ready_next;
	logic        valid_reg,  valid_next;
	logic [31:0] ea_reg,     ea_next;
	logic        isreg_reg,  isreg_next;
	logic        isimm_reg,  isimm_next;
	logic [31:0] opval_reg,  opval_next;
	logic        wr_reg,     wr_next;
	logic [2:0]  wsel_reg,   wsel_next;
	logic [31:0] wval_reg,   wval_next;
	logic        mreq_reg,   mreq_next;
	logic [31:0] maddr_reg,  maddr_next;
	logic [31:0] post_reg,   post_next;

	logic        accept;
	logic [31:0] dreg_val;
	logic [31:0] areg_val;
	logic [31:0] idx_val;
	logic [31:0] bd_ext;
	logic [31:0] od_ext;
	logic [31:0] step;
	logic [31:0] d8_ext;
	logic [31:0] d16_ext;
	logic [31:0] imm_val;

	eau_index_scale u_index (
		.data_regs     (data_regs),
		.addr_regs     (addr_regs),
		.index_reg_sel (index_reg_sel),
		.index_is_addr (index_is_addr),
		.index_long    (index_long),
		.index_scale   (index_scale),
		.scaled_index  (idx_val)
	);

	always_comb begin
		accept   = req_valid && (state_reg == ST_IDLE);
		dreg_val = eau_pick(data_regs, data_reg_sel); // RL1
		areg_val = eau_pick(addr_regs, addr_reg_sel); // RL2
		d8_ext   = eau_sext8(short_disp_byte); // RL3
		d16_ext  = eau_sext16(short_disp_word); // RL3
		bd_ext   = eau_disp(base_disp, base_disp_long); // RL6
		od_ext   = outer_disp_used ? eau_disp(outer_disp, outer_disp_long) : EAU_ZERO; // RL7
		step     = eau_step(req_size); // RL16
		case (req_size) // RL13
			SIZE_BYTE: imm_val = {24'h00_0000, ext_data[7:0]};
			SIZE_WORD: imm_val = {16'h0000, ext_data[15:0]};
			default:   imm_val = ext_data;
		endcase
	end

	always_comb begin
		state_next = state_reg;
		ready_next = ready_reg;
		valid_next = 1'b0;
		ea_next    = ea_reg;
		isreg_next = isreg_reg;
		isimm_next = isimm_reg;
		opval_next = opval_reg;
		wr_next    = 1'b0;
		wsel_next  = wsel_reg;
		wval_next  = wval_reg;
		mreq_next  = mreq_reg;
		maddr_next = maddr_reg;
		post_next  = post_reg;
		case (state_reg)
			ST_IDLE: begin
				if (accept) begin // RL14
					valid_next = 1'b1;
					isreg_next = 1'b0;
					isimm_next = 1'b0;
					opval_next = EAU_ZERO;
					ea_next    = EAU_ZERO;
					wsel_next  = addr_reg_sel;
					case (req_mode)
						MODE_DREG: begin
							isreg_next = 1'b1;
							opval_next = dreg_val; // RL1
						end
						MODE_AREG: begin
							isreg_next = 1'b1;
							opval_next = areg_val; // RL2
						end
						MODE_AIND:    ea_next = areg_val; // RL2
						MODE_APOST: begin
							ea_next   = areg_val; // RL12
							wr_next   = 1'b1;
							wval_next = areg_val + step; // RL16
						end
						MODE_APRE: begin
							ea_next   = areg_val - step; // RL12
							wr_next   = 1'b1;
							wval_next = areg_val - step; // RL16
						end
						MODE_ADISP:   ea_next = areg_val + d16_ext; // RL3
						MODE_AIDX8:   ea_next = areg_val + d8_ext + idx_val; // RL11
						MODE_AIDXBD:  ea_next = areg_val + bd_ext + idx_val; // RL6
						MODE_PCDISP:  ea_next = pc + d16_ext; // RL10
						MODE_PCIDX8:  ea_next = pc + d8_ext + idx_val; // RL11
						MODE_PCIDXBD: ea_next = pc + bd_ext + idx_val;
						MODE_AMIPOST, MODE_PCMIPOST: begin
							valid_next = 1'b0;
							ready_next = 1'b0;
							mreq_next  = 1'b1;
							state_next = ST_FETCH;
							maddr_next = ((req_mode == MODE_AMIPOST) ? areg_val : pc) + bd_ext; // RL8
							post_next  = idx_val + od_ext; // RL9
						end
						MODE_AMIPRE, MODE_PCMIPRE: begin
							valid_next = 1'b0;
							ready_next = 1'b0;
							mreq_next  = 1'b1;
							state_next = ST_FETCH;
							maddr_next = ((req_mode == MODE_AMIPRE) ? areg_val : pc) + bd_ext + idx_val; // RL9
							post_next  = od_ext; // RL7
						end
						MODE_ABSW:    ea_next = eau_sext16(ext_data[15:0]); // RL15
						MODE_ABSL:    ea_next = ext_data; // RL15
						MODE_IMM: begin
							isimm_next = 1'b1;
							opval_next = imm_val; // RL13
						end
						default: valid_next = 1'b0;
					endcase
				end
			end
			ST_FETCH: begin
				if (mem_rd_ack) begin
					ea_next    = mem_rd_data + post_reg; // RL8
					valid_next = 1'b1;
					mreq_next  = 1'b0;
					ready_next = 1'b1;
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
				ready_next = EAU_READY_RST;
				mreq_next  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			ready_reg <= EAU_READY_RST;
			valid_reg <= 1'b0;
			ea_reg    <= EAU_ZERO;
			isreg_reg <= 1'b0;
			isimm_reg <= 1'b0;
			opval_reg <= EAU_ZERO;
			wr_reg    <= 1'b0;
			wsel_reg  <= 3'h0;
			wval_reg  <= EAU_ZERO;
			mreq_reg  <= 1'b0;
			maddr_reg <= EAU_ZERO;
			post_reg  <= EAU_ZERO;
		end else begin
			state_reg <= state_next;
			ready_reg <= ready_next;
			valid_reg <= valid_next;
			ea_reg    <= ea_next;
			isreg_reg <= isreg_next;
			isimm_reg <= isimm_next;
			opval_reg <= opval_next;
			wr_reg    <= wr_next;
			wsel_reg  <= wsel_next;
			wval_reg  <= wval_next;
			mreq_reg  <= mreq_next;
			maddr_reg <= maddr_next;
			post_reg  <= post_next;
		end
	end

	assign req_ready      = ready_reg;
	assign ea_valid       = valid_reg;
	assign ea_addr        = ea_reg;
	assign operand_is_reg = isreg_reg;
	assign operand_is_imm = isimm_reg;
	assign operand_value  = opval_reg;
	assign an_wr_en       = wr_reg;
	assign an_wr_sel      = wsel_reg;
	assign an_wr_val      = wval_reg;
	assign mem_rd_req     = mreq_reg;
	assign mem_rd_addr    = maddr_reg;

	// checks
	sequence s_fetch_done;
		mem_rd_req && mem_rd_ack;
	endsequence

	sequence s_result_from_memory;
		ea_valid && (ea_addr == $past(mem_rd_data) + $past(post_reg));
	endsequence

	property p_dreg_read;
		@(posedge clk) disable iff (rst)
		accept && req_mode == MODE_DREG |=> operand_is_reg && operand_value == $past(dreg_val) && ea_valid;
	endproperty
	a_dreg_read: assert property (p_dreg_read) else $error("data register operand wrong"); // RL1

	property p_pc_disp;
		@(posedge clk) disable iff (rst)
		accept && req_mode == MODE_PCDISP |=> ea_valid && ea_addr == $past(pc) + {{16{$past(short_disp_word[15])}},
			$past(short_disp_word)};
	endproperty
	a_pc_disp: assert property (p_pc_disp) else $error("pc relative address wrong"); // RL10

	property p_postinc;
		@(posedge clk) disable iff (rst)
		accept && req_mode == MODE_APOST |=> ea_addr == $past(areg_val) && an_wr_en
			&& an_wr_val == $past(areg_val) + $past(step) ##1 (!an_wr_en || $past(accept));
	endproperty
	a_postinc: assert property (p_postinc) else $error("postincrement wrong"); // RL12

	property p_predec_step;
		@(posedge clk) disable iff (rst)
		accept && req_mode == MODE_APRE && req_size == SIZE_WORD |=> ea_addr == $past(areg_val) - 32'h0000_0002
			&& an_wr_val == ea_addr;
	endproperty
	a_predec_step: assert property (p_predec_step) else $error("predecrement step wrong"); // RL16

	property p_idx8;
		@(posedge clk) disable iff (rst)
		accept && req_mode == MODE_AIDX8 |=> ea_addr == $past(areg_val) + {{24{$past(short_disp_byte[7])}},
			$past(short_disp_byte)} + $past(idx_val);
	endproperty
	a_idx8: assert property (p_idx8) else $error("short indexed address wrong"); // RL11

	property p_abs_short;
		@(posedge clk) disable iff (rst)
		accept && req_mode == MODE_ABSW |=> ea_addr[31:16] == {16{ea_addr[15]}} && ea_addr[15:0] == $past(ext_data[15:0]);
	endproperty
	a_abs_short: assert property (p_abs_short) else $error("absolute short not sign extended"); // RL15

	property p_imm_byte;
		@(posedge clk) disable iff (rst)
		accept && req_mode == MODE_IMM && req_size == SIZE_BYTE |=> operand_is_imm
			&& operand_value == {24'h00_0000, $past(ext_data[7:0])};
	endproperty
	a_imm_byte: assert property (p_imm_byte) else $error("byte immediate wrong"); // RL13

	property p_indirect_fetch;
		@(posedge clk) disable iff (rst)
		accept && (req_mode == MODE_AMIPRE) |=> mem_rd_req && !ea_valid
			&& mem_rd_addr == $past(areg_val) + $past(bd_ext) + $past(idx_val);
	endproperty
	a_indirect_fetch: assert property (p_indirect_fetch) else $error("pre-indexed fetch address wrong"); // RL9

	property p_indirect_result;
		@(posedge clk) disable iff (rst)
		s_fetch_done |=> s_result_from_memory ##1 (!ea_valid || $past(accept));
	endproperty
	a_indirect_result: assert property (p_indirect_result) else $error("indirect result wrong"); // RL8

	property p_outer_after;
		@(posedge clk) disable iff (rst)
		accept && req_mode == MODE_PCMIPOST && outer_disp_used |=> post_reg == $past(idx_val) + $past(od_ext);
	endproperty
	a_outer_after: assert property (p_outer_after) else $error("outer displacement misplaced"); // RL7

endmodule

// [verification/eau_tb.sv]
`timescale 1ns/10ps
module tb
	import eau_pkg::*;
;
	logic         clk, rst, req_valid, index_is_addr, index_long, base_disp_long;
	logic         outer_disp_used, outer_disp_long, mem_rd_ack;
	eau_mode_t    req_mode;
	eau_size_t    req_size;
	logic [2:0]   data_reg_sel, addr_reg_sel, index_reg_sel;
	logic [1:0]   index_scale;
	logic [7:0]   short_disp_byte;
	logic [15:0]  short_disp_word;
	logic [31:0]  base_disp, outer_disp, ext_data, pc, mem_rd_data, rd_addr;
	logic [255:0] data_regs, addr_regs;
	logic         req_ready, ea_valid, operand_is_reg, operand_is_imm, an_wr_en, mem_rd_req;
	logic [31:0]  ea_addr, operand_value, an_wr_val, mem_rd_addr;
	logic [2:0]   an_wr_sel;
	int           fails, checks;
	localparam logic [31:0] MEMW = 32'h4000_0000;
	localparam logic [31:0] D3W  = 32'hFFFF_8001;

	eau_unit i_dut (
		.clk             (clk),
		.rst             (rst),
		.req_valid       (req_valid),
		.req_mode        (req_mode),
		.req_size        (req_size),
		.data_reg_sel    (data_reg_sel),
		.addr_reg_sel    (addr_reg_sel),
		.index_reg_sel   (index_reg_sel),
		.index_is_addr   (index_is_addr),
		.index_long      (index_long),
		.index_scale     (index_scale),
		.short_disp_byte (short_disp_byte),
		.short_disp_word (short_disp_word),
		.base_disp       (base_disp),
		.base_disp_long  (base_disp_long),
		.outer_disp      (outer_disp),
		.outer_disp_used (outer_disp_used),
		.outer_disp_long (outer_disp_long),
		.ext_data        (ext_data),
		.pc              (pc),
		.data_regs       (data_regs),
		.addr_regs       (addr_regs),
		.mem_rd_ack      (mem_rd_ack),
		.mem_rd_data     (mem_rd_data),
		.req_ready       (req_ready),
		.ea_valid        (ea_valid),
		.ea_addr         (ea_addr),
		.operand_is_reg  (operand_is_reg),
		.operand_is_imm  (operand_is_imm),
		.operand_value   (operand_value),
		.an_wr_en        (an_wr_en),
		.an_wr_sel       (an_wr_sel),
		.an_wr_val       (an_wr_val),
		.mem_rd_req      (mem_rd_req),
		.mem_rd_addr     (mem_rd_addr)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	function automatic logic [31:0] dr(input int n);
		return data_regs[n*32 +: 32];
	endfunction

	function automatic logic [31:0] ar(input int n);
		return addr_regs[n*32 +: 32];
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic stop_test;
		if (fails == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// request at a falling edge, one stalled cycle before each memory answer
	task automatic go(input eau_mode_t m, input eau_size_t s);
		int n;
		@(negedge clk);
		req_mode = m;
		req_size = s;
		req_valid = 1'b1;
		@(negedge clk);
		req_valid = 1'b0;
		for (n = 0; n < 20 && ea_valid !== 1'b1; n++) begin
			if (mem_rd_req === 1'b1) begin
				rd_addr = mem_rd_addr;
				chk("busy", {31'h0, req_ready}, 32'h0);
				@(negedge clk);
				chk("rd_held", {31'h0, mem_rd_req}, 32'h1);
				mem_rd_ack = 1'b1;
				@(negedge clk);
				mem_rd_ack = 1'b0;
			end else begin
				@(negedge clk);
			end
		end
		chk("ea_valid", {31'h0, ea_valid}, 32'h1);
		chk("ready", {31'h0, req_ready}, 32'h1);
	endtask

	task automatic t_direct;
		for (int i = 0; i < 8; i++) begin
			data_reg_sel = i[2:0];
			addr_reg_sel = 3'(7 - i);
			go(MODE_DREG, SIZE_LONG);
			chk("dreg", operand_value, dr(i));
			chk("is_reg", {31'h0, operand_is_reg}, 32'h1);
			go(MODE_AREG, SIZE_LONG);
			chk("areg", operand_value, ar(7 - i));
		end
		data_reg_sel = 3'h3;
		go(MODE_DREG, SIZE_BYTE);
		chk("dreg_b", operand_value, dr(3));
	endtask

	task automatic t_step;
		logic [31:0] st;
		addr_reg_sel = 3'h2;
		for (int s = 0; s < 3; s++) begin
			st = 32'h1 << s;
			go(MODE_APOST, eau_size_t'(s));
			chk("post_ea", ea_addr, ar(2));
			chk("post_wr", an_wr_val, ar(2) + st);
			chk("post_en", {29'h0, an_wr_sel, an_wr_en}, 32'h5);
			go(MODE_APRE, eau_size_t'(s));
			chk("pre_ea", ea_addr, ar(2) - st);
			chk("pre_wr", an_wr_val, ar(2) - st);
		end
		go(MODE_AIND, SIZE_WORD);
		chk("ind_en", {31'h0, an_wr_en}, 32'h0);
		chk("ind", ea_addr, ar(2));
	endtask

	task automatic t_disp;
		addr_reg_sel = 3'h1;
		short_disp_word = 16'hFFF0;
		go(MODE_ADISP, SIZE_LONG);
		chk("adisp", ea_addr, ar(1) - 32'h10);
		go(MODE_PCDISP, SIZE_LONG);
		chk("pcdisp", ea_addr, pc - 32'h10);
	endtask

	task automatic t_index;
		short_disp_byte = 8'h80;
		for (int sc = 0; sc < 4; sc++) begin
			index_scale = sc[1:0];
			{index_is_addr, index_long, index_reg_sel} = 5'h03;
			go(MODE_AIDX8, SIZE_LONG);
			chk("aidx8", ea_addr, ar(1) - 32'h80 + (D3W << sc));
			{index_is_addr, index_long, index_reg_sel} = 5'h1C;
			go(MODE_PCIDX8, SIZE_LONG);
			chk("pcidx8", ea_addr, pc - 32'h80 + (ar(4) << sc));
		end
		index_scale = 2'h1;
		{index_is_addr, index_long, index_reg_sel} = 5'h0B;
		base_disp = 32'h0001_8000;
		for (int l = 0; l < 2; l++) begin
			base_disp_long = l[0];
			go(MODE_AIDXBD, SIZE_LONG);
			chk("aidxbd", ea_addr, ar(1) + (l ? base_disp : 32'hFFFF_8000) + (dr(3) << 1));
			go(MODE_PCIDXBD, SIZE_LONG);
			chk("pcidxbd", ea_addr, pc + (l ? base_disp : 32'hFFFF_8000) + (dr(3) << 1));
		end
	endtask

	task automatic t_mind;
		logic [31:0] ix, od;
		ix = dr(3) << 1;
		base_disp = 32'h0000_0100;
		base_disp_long = 1'b1;
		outer_disp = 32'h0003_8000;
		for (int k = 0; k < 3; k++) begin
			outer_disp_used = (k != 0);
			outer_disp_long = (k == 2);
			od = (k == 0) ? 32'h0 : (k == 1) ? 32'hFFFF_8000 : outer_disp;
			go(MODE_AMIPOST, SIZE_LONG);
			chk("mipost_in", rd_addr, ar(1) + 32'h100);
			chk("mipost", ea_addr, MEMW + ix + od);
			go(MODE_AMIPRE, SIZE_LONG);
			chk("mipre_in", rd_addr, ar(1) + 32'h100 + ix);
			chk("mipre", ea_addr, MEMW + od);
			go(MODE_PCMIPOST, SIZE_LONG);
			chk("pcmipost", ea_addr, MEMW + ix + od);
			chk("pcmipost_in", rd_addr, pc + 32'h100);
			go(MODE_PCMIPRE, SIZE_LONG);
			chk("pcmipre_in", rd_addr, pc + 32'h100 + ix);
			chk("pcmipre", ea_addr, MEMW + od);
		end
	endtask

	task automatic t_abs;
		ext_data = 32'h1234_9ABC;
		go(MODE_ABSW, SIZE_LONG);
		chk("absw", ea_addr, 32'hFFFF_9ABC);
		go(MODE_ABSL, SIZE_LONG);
		chk("absl", ea_addr, 32'h1234_9ABC);
		for (int s = 0; s < 3; s++) begin
			go(MODE_IMM, eau_size_t'(s));
			chk("imm", operand_value, (s == 0) ? 32'hBC : (s == 1) ? 32'h9ABC : ext_data);
			chk("is_imm", {31'h0, operand_is_imm}, 32'h1);
		end
	endtask

	initial begin
		{rst, req_valid, index_is_addr, index_long, base_disp_long} = 5'h10;
		{outer_disp_used, outer_disp_long, mem_rd_ack} = 3'h0;
		req_mode = MODE_DREG;
		req_size = SIZE_LONG;
		{data_reg_sel, addr_reg_sel, index_reg_sel, index_scale} = 11'h0;
		{short_disp_byte, short_disp_word} = 24'h0;
		{base_disp, outer_disp, ext_data} = 96'h0;
		pc = 32'h0010_2000;
		mem_rd_data = MEMW;
		for (int i = 0; i < 8; i++) begin
			data_regs[i*32 +: 32] = 32'hD000_0010 + i * 32'h100;
			addr_regs[i*32 +: 32] = 32'hA000_1000 + i * 32'h10;
		end
		data_regs[3*32 +: 32] = 32'h1234_8001;
		fails = 0;
		checks = 0;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		chk("rst_out", {28'h0, req_ready, ea_valid, mem_rd_req, an_wr_en}, 32'h8);
		t_direct();
		t_step();
		t_disp();
		t_index();
		t_mind();
		t_abs();
		stop_test();
	end

	initial begin
		#(25 * 5000);
		fails++;
		stop_test();
	end
endmodule
